// [hdl/lmrb_consts.vh]
// Constants for the line monitor register bank: offsets, fields, reset values.
// Functional notes
// - Six-bit low battery setting, 1.5 V per code, default -24 V.
// - Three-bit pointer picks transistor one to six; codes 110 and 111 undefined.
// - Read-only power register shows live power of the selected transistor.
// - Transistors one, two, five, six scale at 30.4 mW per count.
// - Transistors three and four scale at 3.62 mW per count.
// - Loop voltage sign in bit 6: zero tip above ring, one below.
// - Loop voltage magnitude, six bits at 1.5 V per count.
// - Loop current direction in bit 6: zero forward, one reverse.
// - Loop current magnitude, six bits at 1.25 mA per count.
// - Live tip-to-ground voltage, eight bits, .376 V per count negative-going.
// - Live ring-to-ground voltage, same scaling as tip.
`ifndef LMRB_CONSTS_VH
`define LMRB_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LMRB_OFS_LOW_BATTERY    8'h4B
`define LMRB_OFS_POWER_POINTER  8'h4C
`define LMRB_OFS_POWER_READING  8'h4D
`define LMRB_OFS_LOOP_VOLTAGE   8'h4E
`define LMRB_OFS_LOOP_CURRENT   8'h4F
`define LMRB_OFS_TIP_VOLTAGE    8'h50
`define LMRB_OFS_RING_VOLTAGE   8'h51

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define LMRB_LOW_BATT_W         6
`define LMRB_POINTER_W          3
`define LMRB_MAG_W              6
`define LMRB_SIGN_BIT           6
// -24 V at 1.5 V per code is code 16
`define LMRB_LOW_BATT_RST       6'h10
`define LMRB_POINTER_RST        3'h0
`define LMRB_POINTER_LAST       3'h5
// Transistors three and four are the small ones on the fine power scale
`define LMRB_SMALL_FIRST        3'h2
`define LMRB_SMALL_LAST         3'h3
`define LMRB_POWER_CHANNELS     6
`define LMRB_UNMAPPED_READ      8'h00

`endif

// [hdl/lmrb_sync.v]
// Two-stage synchroniser for a bus of measurement inputs.
`timescale 1ns/100ps
`default_nettype none
module lmrb_sync #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second; the converters run outside this clock domain
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // lmrb_sync
`default_nettype wire

// [hdl/lmrb_power_mux.v]
// Power selector: picks one transistor's live power by pointer.
`include "lmrb_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module lmrb_power_mux (
  input  wire [2:0]  pointer,
  input  wire [47:0] power_all,
  output reg  [7:0]  power_sel,
  output reg         low_range
);

  // Undefined pointer codes read zero rather than a stale channel
  always @* begin
    power_sel = 8'h00;
    low_range = 1'b0;
    if (pointer <= `LMRB_POINTER_LAST) begin
      power_sel = power_all[pointer*8 +: 8];
    end
    // Channels three and four are the small transistors, 3.62 mW per count
    low_range = (pointer == `LMRB_SMALL_FIRST) || (pointer == `LMRB_SMALL_LAST);
  end

endmodule // lmrb_power_mux
`default_nettype wire

// [hdl/lmrb_bank.v]
// Line monitor register bank: low battery setting, pointer and measurement reads.
`include "lmrb_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module lmrb_bank (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_q,
  output reg  [5:0]  low_battery_level_q,
  output reg         power_low_range_q,
  input  wire [47:0] meas_power_all,
  input  wire        meas_loop_voltage_sign,
  input  wire [5:0]  meas_loop_voltage_magnitude,
  input  wire        meas_loop_current_sign,
  input  wire [5:0]  meas_loop_current_magnitude,
  input  wire [7:0]  meas_tip_to_ground,
  input  wire [7:0]  meas_ring_to_ground
);

  // ****************************************************************
  // Measurement synchronisers
  // ****************************************************************
  localparam POWER_CHANNELS = `LMRB_POWER_CHANNELS;

  wire [47:0] power_all_s;
  wire [47:0] power_all_h;
  wire [29:0] loop_line_s;
  reg  [2:0]  power_select_pointer_q;
  wire [7:0]  transistor_power_value;
  wire        low_range;

  // Measurements come from the converters outside this clock domain
  lmrb_sync #(.WIDTH(48)) u_sync_power (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (meas_power_all),
    .sync_out (power_all_s)
  );

  lmrb_sync #(.WIDTH(30)) u_sync_line (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({meas_loop_voltage_sign, meas_loop_voltage_magnitude,
                meas_loop_current_sign, meas_loop_current_magnitude,
                meas_tip_to_ground, meas_ring_to_ground}),
    .sync_out (loop_line_s)
  );

  lmrb_power_mux u_power_mux (
    .pointer   (power_select_pointer_q),
    .power_all (power_all_h),
    .power_sel (transistor_power_value),
    .low_range (low_range)
  );

  // ****************************************************************
  // Settle filters
  // ****************************************************************
  // Two flip-flops stop metastability but not tearing: a word caught mid-change
  // can mix old and new bits. A reading is taken only once two successive
  // synchronised samples agree, at the cost of two more cycles of latency.
  genvar ch;
  generate
    for (ch = 0; ch < POWER_CHANNELS; ch = ch + 1) begin : g_power_settle
      reg  [7:0] prev_q;
      reg  [7:0] hold_q;
      wire [7:0] sample = power_all_s[ch*8 +: 8];

      // Each channel settles on its own, so one busy converter stalls no other
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          prev_q <= 8'h00;
          hold_q <= 8'h00;
        end else begin
          prev_q <= sample;
          if (sample == prev_q) begin
            hold_q <= sample;
          end
        end
      end

      assign power_all_h[ch*8 +: 8] = hold_q;
    end
  endgenerate

  wire [6:0] loop_voltage_s = loop_line_s[29:23];
  wire [6:0] loop_current_s = loop_line_s[22:16];
  wire [7:0] tip_s          = loop_line_s[15:8];
  wire [7:0] ring_s         = loop_line_s[7:0];

  reg  [6:0] loop_voltage_prev_q;
  reg  [6:0] loop_voltage_hold_q;
  reg  [6:0] loop_current_prev_q;
  reg  [6:0] loop_current_hold_q;
  reg  [7:0] tip_prev_q;
  reg  [7:0] tip_hold_q;
  reg  [7:0] ring_prev_q;
  reg  [7:0] ring_hold_q;

  // Sign settles with its magnitude, so a reading never pairs a stale sign
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loop_voltage_prev_q <= 7'h00;
      loop_voltage_hold_q <= 7'h00;
      loop_current_prev_q <= 7'h00;
      loop_current_hold_q <= 7'h00;
      tip_prev_q          <= 8'h00;
      tip_hold_q          <= 8'h00;
      ring_prev_q         <= 8'h00;
      ring_hold_q         <= 8'h00;
    end else begin
      loop_voltage_prev_q <= loop_voltage_s;
      loop_current_prev_q <= loop_current_s;
      tip_prev_q          <= tip_s;
      ring_prev_q         <= ring_s;
      if (loop_voltage_s == loop_voltage_prev_q) begin
        loop_voltage_hold_q <= loop_voltage_s;
      end
      if (loop_current_s == loop_current_prev_q) begin
        loop_current_hold_q <= loop_current_s;
      end
      if (tip_s == tip_prev_q) begin
        tip_hold_q <= tip_s;
      end
      if (ring_s == ring_prev_q) begin
        ring_hold_q <= ring_s;
      end
    end
  end

  wire       loop_voltage_sign      = loop_voltage_hold_q[6];
  wire [5:0] loop_voltage_magnitude = loop_voltage_hold_q[5:0];
  wire       loop_current_sign      = loop_current_hold_q[6];
  wire [5:0] loop_current_magnitude = loop_current_hold_q[5:0];
  wire [7:0] tip_to_ground_value    = tip_hold_q;
  wire [7:0] ring_to_ground_value   = ring_hold_q;

  // ****************************************************************
  // Writable settings
  // ****************************************************************
  // Write strobes per setting; every other offset decodes to nothing
  wire wr_low_battery   = reg_wr_en && (reg_addr == `LMRB_OFS_LOW_BATTERY);
  wire wr_power_pointer = reg_wr_en && (reg_addr == `LMRB_OFS_POWER_POINTER);

  // Only the two settings take writes; measurement offsets fall through
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_battery_level_q    <= `LMRB_LOW_BATT_RST;
      power_select_pointer_q <= `LMRB_POINTER_RST;
    end else begin
      if (wr_low_battery) begin
        low_battery_level_q <= reg_wdata[5:0];
      end
      if (wr_power_pointer) begin
        power_select_pointer_q <= reg_wdata[2:0];
      end
      // Writes to measurement offsets have no target
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [7:0] rdata_d;

  // Upper bits zero-filled; sign sits in bit 6
  always @* begin
    rdata_d = `LMRB_UNMAPPED_READ;
    case (reg_addr)
      `LMRB_OFS_LOW_BATTERY:   rdata_d = {2'h0, low_battery_level_q};
      `LMRB_OFS_POWER_POINTER: rdata_d = {5'h00, power_select_pointer_q};
      `LMRB_OFS_POWER_READING: rdata_d = transistor_power_value;
      `LMRB_OFS_LOOP_VOLTAGE:  rdata_d = {1'h0, loop_voltage_sign,
                                          loop_voltage_magnitude};
      `LMRB_OFS_LOOP_CURRENT:  rdata_d = {1'h0, loop_current_sign,
                                          loop_current_magnitude};
      `LMRB_OFS_TIP_VOLTAGE:   rdata_d = tip_to_ground_value;
      `LMRB_OFS_RING_VOLTAGE:  rdata_d = ring_to_ground_value;
      default:                 rdata_d = `LMRB_UNMAPPED_READ;
    endcase
  end

  // Read data registered: valid the cycle after the strobe, holds till next
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q       <= 8'h00;
      power_low_range_q <= 1'b0;
    end else begin
      if (reg_rd_en) begin
        reg_rdata_q <= rdata_d;
      end
      power_low_range_q <= low_range;
    end
  end

endmodule // lmrb_bank
`default_nettype wire

// [testbench/lmrb_checker.sv]
// Port checker for the line monitor register bank.
`timescale 1ns/100ps
`default_nettype none
module lmrb_checker (
  input wire       sys_clk,
  input wire       rst,
  input wire       reg_wr_en,
  input wire       reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire [5:0] low_battery_level_q,
  input wire       power_low_range_q,
  input wire       meas_loop_voltage_sign,
  input wire [5:0] meas_loop_voltage_magnitude,
  input wire [7:0] meas_tip_to_ground
);
  // ****************
  // Port relations
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Inputs must sit still four edges: two to synchronise, two to settle
  wire [6:0] lv = {meas_loop_voltage_sign, meas_loop_voltage_magnitude};
  wire [7:0] tp = meas_tip_to_ground;
  wire       wb = reg_wr_en && reg_addr == 8'h4B;
  wire       wp = reg_wr_en && reg_addr == 8'h4C;
  lowbat_write_a: assert property (wb |=> {2'b00, low_battery_level_q} ==
    ($past(reg_wdata) & 8'h3F)) else $error("low battery not written");
  lowbat_hold_a: assert property (!wb |=> $stable(low_battery_level_q))
    else $error("low battery changed");
  range_low_a: assert property (wp && reg_wdata[2:1] == 2'b01 |=> ##1 power_low_range_q)
    else $error("low range missing");
  range_high_a: assert property (wp && reg_wdata[2:1] != 2'b01 |=> ##1 !power_low_range_q)
    else $error("low range wrong");
  lowbat_read_a: assert property (reg_rd_en && reg_addr == 8'h4B |=>
    reg_rdata_q == {2'b00, $past(low_battery_level_q)}) else $error("low battery read");
  loop_rsvd_a: assert property (reg_rd_en && reg_addr[7:1] == 7'h27 |=> !reg_rdata_q[7])
    else $error("loop bit 7 set");
  tip_read_a: assert property (reg_rd_en && reg_addr == 8'h50 && $stable(tp) &&
    tp == $past(tp, 2) && tp == $past(tp, 3) && tp == $past(tp, 4) |=>
    reg_rdata_q == $past(tp)) else $error("tip read");
  loopv_read_a: assert property (reg_rd_en && reg_addr == 8'h4E && $stable(lv) &&
    lv == $past(lv, 2) && lv == $past(lv, 3) && lv == $past(lv, 4) |=>
    reg_rdata_q == {1'b0, $past(lv)})
    else $error("loop voltage read");
  cover property (wp ##2 power_low_range_q);
  cover property (wb);
  cover property (reg_rd_en && reg_addr == 8'h4E);
endmodule // lmrb_checker
bind lmrb_bank lmrb_checker i_chk (.*);
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the line monitor register bank.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [47:0] meas_power_all = 48'h665544332211;
  logic        meas_loop_voltage_sign = 1'b0;
  logic [5:0]  meas_loop_voltage_magnitude = 6'h00;
  logic        meas_loop_current_sign = 1'b0;
  logic [5:0]  meas_loop_current_magnitude = 6'h00;
  logic [7:0]  meas_tip_to_ground = 8'h00;
  logic [7:0]  meas_ring_to_ground = 8'h00;
  wire  [7:0]  reg_rdata_q;
  wire  [5:0]  low_battery_level_q;
  wire         power_low_range_q;
  int          errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #50 sys_clk = ~sys_clk;
  lmrb_bank i_dut (.*);
  // Cycle ceiling, the run needs about 105
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      give_verdict;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask
  // Read data lands on the edge after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1 chk(reg_rdata_q, e);
  endtask
  task automatic t_lowbat;
    chk({2'b00, low_battery_level_q}, 8'h10);
    rd(8'h4B, 8'h10);
    // Code 0x25 stays within the high battery default and a typical external supply
    wr(8'h4B, 8'hE5);
    rd(8'h4B, 8'h25);
    chk({2'b00, low_battery_level_q}, 8'h25);
    $display("low battery test done");
  endtask
  // Every pointer code, reserved bits set in each pointer write
  task automatic t_power;
    for (int p = 0; p < 8; p++) begin
      wr(8'h4B, 8'h00);
      wr(8'h4C, 8'hF8 | 8'(p));
      rd(8'h4C, 8'(p));
      rd(8'h4D, (p < 6) ? 8'(8'h11 * (p + 1)) : 8'h00);
      chk({7'h00, power_low_range_q}, 8'(p == 2 || p == 3));
    end
    $display("power test done");
  endtask
  task automatic t_meas;
    @(posedge sys_clk);
    meas_power_all[31:24] <= 8'hC3;
    meas_loop_voltage_sign <= 1'b1;
    meas_loop_voltage_magnitude <= 6'h3F;
    meas_loop_current_sign <= 1'b1;
    meas_loop_current_magnitude <= 6'h2A;
    meas_tip_to_ground <= 8'hA5;
    meas_ring_to_ground <= 8'h5A;
    for (int a = 8'h4D; a < 8'h53; a++) wr(8'(a), 8'hFF);
    rd(8'h4E, 8'h7F);
    rd(8'h4F, 8'h6A);
    rd(8'h50, 8'hA5);
    rd(8'h51, 8'h5A);
    rd(8'h52, 8'h00);
    // Transistor four changed mid-run: the reading must follow it live
    wr(8'h4C, 8'h03);
    rd(8'h4D, 8'hC3);
    chk({7'h00, power_low_range_q}, 8'h01);
    $display("measurement test done");
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_lowbat;
    t_power;
    t_meas;
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
